//--- include/sco_pkg.sv
// Constants and types for the operand and timing decoder
package sco_pkg;
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	localparam logic [2:0] CYC_3 = 3'h3;
	localparam logic [2:0] CYC_4 = 3'h4;
	localparam logic [2:0] CYC_5 = 3'h5;
	localparam logic [2:0] CNT_LAST = 3'h0;
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [7:0] DIR_SFR_BASE = 8'h80;
	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_IMM = 3'h1,
		MODE_DIR = 3'h2,
		MODE_IND8 = 3'h3,
		MODE_IND16 = 3'h4,
		MODE_REG = 3'h5,
		MODE_IDX = 3'h6,
		MODE_STACK = 3'h7
	} sco_mode_t;
	typedef enum logic [3:0] {
		ALU_NONE = 4'h0, ALU_ADD = 4'h1, ALU_SUM_WITH_CARRY_IN = 4'h2, ALU_DIFF_WITH_BORROW = 4'h3,
		ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_XOR = 4'h6, ALU_PASS = 4'h7,
		ALU_CLR = 4'h8, ALU_CPL = 4'h9, ALU_RL = 4'ha, ALU_RLC = 4'hb,
		ALU_RR = 4'hc, ALU_RRC = 4'hd, ALU_SWAP = 4'he, ALU_LOW_DIGIT_TRADE = 4'hf
	} sco_alu_op_t;
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} sco_state_t;
	typedef struct packed {
		logic [2:0] clocks;
		logic [1:0] len;
		sco_mode_t mode;
		sco_alu_op_t op;
		logic ext;
		logic wr;
		logic jump;
		logic known;
	} sco_dec_t;
endpackage : sco_pkg

//--- include/sco_alu_if.sv
// Operand and flag bundle between the decoder and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface sco_alu_if;
	import sco_pkg::*;
	logic [7:0] a, b, result;
	logic cin, cy, ac, ov, flags;
	sco_alu_op_t op;
	modport core (output a, b, cin, op, input result, cy, ac, ov, flags);
	modport alu (input a, b, cin, op, output result, cy, ac, ov, flags);
endinterface : sco_alu_if
`default_nettype wire

//--- rtl/sco_alu.sv
// Accumulator arithmetic, logic and rotate unit
`timescale 1ns/1ps
`default_nettype none
module sco_alu
	import sco_pkg::*;
(
	// Operands and results
	sco_alu_if.alu bus
);
	logic c;
	logic [8:0] s9, d9;
	logic [4:0] s4, d4;
	logic [7:0] s7, d7;
	// Plain add ignores the incoming carry
	assign c = (bus.op == ALU_ADD) ? 1'b0 : bus.cin;
	assign s9 = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, c};
	assign s4 = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, c};
	assign s7 = {1'b0, bus.a[6:0]} + {1'b0, bus.b[6:0]} + {7'h00, c};
	assign d9 = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, c};
	assign d4 = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, c};
	assign d7 = {1'b0, bus.a[6:0]} - {1'b0, bus.b[6:0]} - {7'h00, c};
	always_comb begin
		bus.result = bus.a;
		bus.cy = bus.cin;
		bus.ac = 1'b0;
		bus.ov = 1'b0;
		bus.flags = 1'b0;
		case (bus.op)
			ALU_ADD, ALU_SUM_WITH_CARRY_IN: begin
				bus.result = s9[7:0];
				bus.cy = s9[8]; // [RL21]
				bus.ac = s4[4]; // [RL21]
				bus.ov = s9[8] ^ s7[7]; // [RL22]
				bus.flags = 1'b1;
			end
			ALU_DIFF_WITH_BORROW: begin
				bus.result = d9[7:0];
				bus.cy = d9[8];
				bus.ac = d4[4];
				bus.ov = d9[8] ^ d7[7];
				bus.flags = 1'b1;
			end
			ALU_AND: bus.result = bus.a & bus.b;
			ALU_OR: bus.result = bus.a | bus.b;
			ALU_XOR: bus.result = bus.a ^ bus.b;
			ALU_PASS: bus.result = bus.b;
			ALU_CLR: bus.result = 8'h00;
			ALU_CPL: bus.result = ~bus.a;
			ALU_RL: bus.result = {bus.a[6:0], bus.a[7]};
			ALU_RR: bus.result = {bus.a[0], bus.a[7:1]};
			ALU_RLC: begin
				bus.result = {bus.a[6:0], bus.cin};
				bus.cy = bus.a[7];
			end
			ALU_RRC: begin
				bus.result = {bus.cin, bus.a[7:1]};
				bus.cy = bus.a[0];
			end
			ALU_SWAP: bus.result = {bus.a[3:0], bus.a[7:4]};
			ALU_LOW_DIGIT_TRADE: bus.result = {bus.a[7:4], bus.b[3:0]};
			default: bus.result = bus.a;
		endcase
	end
endmodule : sco_alu
`default_nettype wire

//--- rtl/sco_core.sv
// Operand addressing and per-instruction clock timing decoder
// Contract
// RL1: Immediate operand comes from code bytes after opcode, no data memory access.
// RL2: Direct mode uses 8-bit field; reaches low 128 RAM bytes and SFRs.
// RL3: 8-bit indirect address from pointer register zero/one of bank, or stack.
// RL4: 16-bit indirect uses only the table pointer; reaches internal and external. Decoder marks every such access as external RAM.
// RL5: Register mode decodes 3-bit opcode field selecting one of eight bank regs.
// RL6: Indexed mode reads program memory only; base plus accumulator.
// RL7: Indexed jump target is base pointer plus accumulator.
// RL8: Add and add with carry: 2 clocks reg/imm, 3 clocks dir/ind.
// RL9: Subtract with borrow: 2 clocks reg/imm, 3 clocks dir/ind.
// RL10: AND/OR/XOR into accumulator: 2 clocks reg/imm, 3 dir/ind.
// RL11: AND/OR/XOR to direct byte: 4 clocks; immediate 3 bytes, acc 2.
// RL12: Rotates and accumulator clear: 1 clock, 1 byte.
// RL13: Nibble swap 1 clock; low digit trade with indirect RAM 4 clocks.
// RL14: Register to accumulator 1 clock; direct, indirect, immediate 2 clocks.
// RL15: Direct to direct copy 3 bytes 4 clocks; immediate to direct 3 bytes 3.
// RL16: Code table read via table pointer or counter: 1 byte, 4 clocks.
// RL17: External RAM 3 clocks, 8-bit pointer write 4; all 1 byte.
// RL18: Push direct 4 clocks, pop direct 3 clocks; both 2 bytes.
// RL19: Trade with register 3 clocks; with direct or indirect 4 clocks.
// RL20: Accumulator to register 2 clocks, to direct 3, to indirect 3.
// RL21: Add sets carry from bit 7 and auxiliary carry from bit 3.
// RL22: Add sets signed wrap flag when exactly one of bits 6, 7 carries.
// RL23: Working register bank comes from the status word bank-select bits.
`timescale 1ns/1ps
`default_nettype none
module sco_core
	import sco_pkg::*;
(
	// Clock, reset and enable
	input wire logic clock,
	input wire logic rstn,
	input wire logic clk_en,
	// Instruction in
	input wire logic op_valid,
	output logic op_ready,
	input wire logic [7:0] opcode,
	input wire logic [7:0] op_byte1,
	input wire logic [7:0] op_byte2,
	// Core state in
	input wire logic [7:0] acc,
	input wire logic carry_in,
	input wire logic [1:0] psw_bank,
	input wire logic [7:0] pointer_reg_zero,
	input wire logic [7:0] pointer_reg_one,
	input wire logic [7:0] stack_ptr,
	input wire logic [15:0] table_pointer16,
	input wire logic [15:0] prog_counter,
	input wire logic [7:0] src_operand,
	// Timing out
	output logic busy,
	output logic done,
	output logic known_op,
	output logic [1:0] byte_len,
	output logic [2:0] clock_count,
	output sco_mode_t addr_mode,
	// Operand addressing out
	output logic [15:0] operand_addr,
	output logic sfr_select,
	output logic [4:0] work_reg_index,
	output logic [15:0] imm_value,
	output logic data_mem_access,
	output logic ext_ram_access,
	output logic mem_write,
	output logic code_read,
	output logic [15:0] code_addr,
	output logic jump_valid,
	output logic [15:0] jump_target,
	// Results out
	output logic [7:0] acc_result,
	output logic carry,
	output logic aux_carry,
	output logic signed_wrap_flag,
	output logic flags_valid
);
	sco_alu_if alu_bus ();
	sco_state_t state;
	sco_dec_t dec;
	logic rst_meta, rst_n_sync, accept;
	logic [2:0] cnt;
	logic [15:0] idx_sum, next_addr, next_imm;
	logic [7:0] alu_b;
	// Low nibble of the accumulator groups selects the source form
	function automatic sco_mode_t sco_form(input logic [3:0] lo);
		case (lo)
			4'h4: return MODE_IMM;
			4'h5: return MODE_DIR;
			4'h6, 4'h7: return MODE_IND8;
			default: return MODE_REG;
		endcase
	endfunction : sco_form
	function automatic sco_dec_t sco_mk(input logic [2:0] c,
		input logic [1:0] l, input sco_mode_t m, input sco_alu_op_t o);
		return '{c, l, m, o, 1'b0, 1'b0, 1'b0, 1'b1};
	endfunction : sco_mk
	function automatic sco_dec_t sco_decode(input logic [7:0] op);
		sco_dec_t d;
		sco_mode_t f;
		d = sco_mk(CYC_1, LEN_1, MODE_NONE, ALU_NONE);
		f = sco_form(op[3:0]);
		if (op[3:2] != 2'b00 && (op[7:4] == 4'h2 || op[7:4] == 4'h3 ||
			op[7:4] == 4'h9 || op[7:6] == 2'b01)
			&& op[7:4] != 4'h7) begin
			d.mode = f;
			d.clocks = (f == MODE_DIR || f == MODE_IND8) ? CYC_3 : CYC_2;
			d.len = (f == MODE_IMM || f == MODE_DIR) ? LEN_2 : LEN_1;
			case (op[7:4])
				4'h2: d.op = ALU_ADD; // [RL8]
				4'h3: d.op = ALU_SUM_WITH_CARRY_IN; // [RL8]
				4'h9: d.op = ALU_DIFF_WITH_BORROW; // [RL9]
				4'h4: d.op = ALU_OR; // [RL10]
				4'h5: d.op = ALU_AND; // [RL10]
				default: d.op = ALU_XOR; // [RL10]
			endcase
		end else if (op[7:5] == 3'b000 && op[3:2] != 2'b00) begin
			// Increment and decrement: only timing and addressing are produced here
			d.mode = (op[3:0] == 4'h4) ? MODE_NONE : f;
			d.clocks = (f == MODE_IMM) ? CYC_2 : (f == MODE_REG) ? CYC_3 : CYC_4;
			d.len = (f == MODE_DIR) ? LEN_2 : LEN_1;
		end else begin
			casez (op)
				8'he4: d = sco_mk(CYC_1, LEN_1, MODE_NONE, ALU_CLR); // [RL12]
				8'h23: d = sco_mk(CYC_1, LEN_1, MODE_NONE, ALU_RL); // [RL12]
				8'h33: d = sco_mk(CYC_1, LEN_1, MODE_NONE, ALU_RLC); // [RL12]
				8'h03: d = sco_mk(CYC_1, LEN_1, MODE_NONE, ALU_RR); // [RL12]
				8'h13: d = sco_mk(CYC_1, LEN_1, MODE_NONE, ALU_RRC); // [RL12]
				8'hc4: d = sco_mk(CYC_1, LEN_1, MODE_NONE, ALU_SWAP); // [RL13]
				8'hf4: d = sco_mk(CYC_2, LEN_1, MODE_NONE, ALU_CPL);
				8'ha3: d = sco_mk(CYC_1, LEN_1, MODE_NONE, ALU_NONE);
				8'ha4: d = sco_mk(CYC_4, LEN_1, MODE_NONE, ALU_NONE);
				8'h84: d = sco_mk(CYC_5, LEN_1, MODE_NONE, ALU_NONE);
				8'hd4: d = sco_mk(CYC_4, LEN_1, MODE_NONE, ALU_NONE);
				8'h52, 8'h42, 8'h62:
					d = sco_mk(CYC_4, LEN_2, MODE_DIR, ALU_NONE); // [RL11]
				8'h53, 8'h43, 8'h63:
					d = sco_mk(CYC_4, LEN_3, MODE_DIR, ALU_NONE); // [RL11]
				8'b1110_1???: d = sco_mk(CYC_1, LEN_1, MODE_REG, ALU_PASS); // [RL14]
				8'he5: d = sco_mk(CYC_2, LEN_2, MODE_DIR, ALU_PASS); // [RL14]
				8'b1110_011?: d = sco_mk(CYC_2, LEN_1, MODE_IND8, ALU_PASS); // [RL14]
				8'h74: d = sco_mk(CYC_2, LEN_2, MODE_IMM, ALU_PASS); // [RL14]
				8'b1111_1???: d = sco_mk(CYC_2, LEN_1, MODE_REG, ALU_NONE); // [RL20]
				8'hf5: d = sco_mk(CYC_3, LEN_2, MODE_DIR, ALU_NONE); // [RL20]
				8'b1111_011?: d = sco_mk(CYC_3, LEN_1, MODE_IND8, ALU_NONE); // [RL20]
				8'b1010_1???: d = sco_mk(CYC_4, LEN_2, MODE_DIR, ALU_NONE);
				8'b0111_1???: d = sco_mk(CYC_2, LEN_2, MODE_IMM, ALU_NONE);
				8'b1000_1???: d = sco_mk(CYC_3, LEN_2, MODE_REG, ALU_NONE);
				8'h85: d = sco_mk(CYC_4, LEN_3, MODE_DIR, ALU_NONE); // [RL15]
				8'h75: d = sco_mk(CYC_3, LEN_3, MODE_DIR, ALU_NONE); // [RL15]
				8'b1000_011?: d = sco_mk(CYC_4, LEN_2, MODE_IND8, ALU_NONE);
				8'b1010_011?: d = sco_mk(CYC_4, LEN_2, MODE_IND8, ALU_NONE);
				8'b0111_011?: d = sco_mk(CYC_3, LEN_2, MODE_IND8, ALU_NONE);
				8'h90: d = sco_mk(CYC_3, LEN_3, MODE_IMM, ALU_NONE);
				8'h93, 8'h83: d = sco_mk(CYC_4, LEN_1, MODE_IDX, ALU_PASS); // [RL16]
				8'h73: begin
					d = sco_mk(CYC_3, LEN_1, MODE_IDX, ALU_NONE);
					d.jump = 1'b1; // [RL7]
				end
				8'b1110_001?, 8'he0, 8'hf0: begin
					d = sco_mk(CYC_3, LEN_1, op[1] ? MODE_IND8 : MODE_IND16,
						op[4] ? ALU_NONE : ALU_PASS); // [RL17]
					d.ext = 1'b1;
					d.wr = op[4];
				end
				8'b1111_001?: begin
					d = sco_mk(CYC_4, LEN_1, MODE_IND8, ALU_NONE); // [RL17]
					d.ext = 1'b1;
					d.wr = 1'b1;
				end
				8'hc0: d = sco_mk(CYC_4, LEN_2, MODE_STACK, ALU_NONE); // [RL18]
				8'hd0: d = sco_mk(CYC_3, LEN_2, MODE_STACK, ALU_NONE); // [RL18]
				8'b1100_1???: d = sco_mk(CYC_3, LEN_1, MODE_REG, ALU_PASS); // [RL19]
				8'hc5: d = sco_mk(CYC_4, LEN_2, MODE_DIR, ALU_PASS); // [RL19]
				8'b1100_011?: d = sco_mk(CYC_4, LEN_1, MODE_IND8, ALU_PASS); // [RL19]
				8'b1101_011?: d = sco_mk(CYC_4, LEN_1, MODE_IND8, ALU_LOW_DIGIT_TRADE); // [RL13]
				default: d.known = 1'b0;
			endcase
		end
		return d;
	endfunction : sco_decode
	// Reset is released through two stages so every flop leaves it together
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n_sync <= 1'b0;
		end else if (clk_en) begin
			rst_meta <= 1'b1;
			rst_n_sync <= rst_meta;
		end
	end

	assign dec = sco_decode(opcode);
	assign done = (state == ST_RUN) && (cnt == CNT_LAST);
	assign busy = (state == ST_RUN);
	// Accepting in the finishing cycle keeps back-to-back issue gap-free
	assign op_ready = rst_n_sync && ((state == ST_IDLE) || done);
	assign accept = op_valid && op_ready;
	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state <= ST_IDLE;
			cnt <= CNT_LAST;
		end else if (clk_en) begin
			if (accept) begin
				state <= ST_RUN;
				cnt <= 3'(dec.clocks - CYC_1); // [RL8] [RL9] [RL17]
			end else if (done) begin
				state <= ST_IDLE;
			end else if (state == ST_RUN) begin
				cnt <= 3'(cnt - CYC_1);
			end
		end
	end

	// Base is the table pointer except for the counter-relative read
	assign idx_sum = (opcode[4] ? table_pointer16 : prog_counter)
		+ {8'h00, acc}; // [RL6] [RL7]
	always_comb begin
		next_addr = 16'h0000;
		case (dec.mode)
			MODE_DIR: next_addr = {8'h00, op_byte1}; // [RL2]
			MODE_IND8: next_addr = {8'h00, opcode[0] ? pointer_reg_one
				: pointer_reg_zero}; // [RL3]
			MODE_STACK: next_addr = {8'h00, stack_ptr}; // [RL3]
			MODE_IND16: next_addr = table_pointer16; // [RL4]
			MODE_REG: next_addr = {11'h000, psw_bank, opcode[2:0]}; // [RL5]
			MODE_IDX: next_addr = idx_sum; // [RL6]
			default: next_addr = 16'h0000;
		endcase
	end
	// Constants are read straight from the code bytes [RL1]
	always_comb begin
		next_imm = {8'h00, op_byte1};
		if (opcode == 8'h90)
			next_imm = {op_byte1, op_byte2};
		else if ((opcode[3:1] == 3'b001 || opcode == 8'h75)
			&& dec.mode == MODE_DIR)
			next_imm = {8'h00, op_byte2};
	end
	assign alu_b = (dec.mode == MODE_IMM) ? op_byte1 : src_operand; // [RL1]
	assign alu_bus.a = acc;
	assign alu_bus.b = alu_b;
	assign alu_bus.cin = carry_in;
	assign alu_bus.op = dec.op;
	sco_alu sco_alu_inst (.bus(alu_bus.alu));

	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			known_op <= 1'b0;
			byte_len <= LEN_1;
			clock_count <= CYC_1;
			addr_mode <= MODE_NONE;
			data_mem_access <= 1'b0;
			ext_ram_access <= 1'b0;
			mem_write <= 1'b0;
			code_read <= 1'b0;
			jump_valid <= 1'b0;
		end else if (clk_en && accept) begin
			known_op <= dec.known;
			byte_len <= dec.len;
			clock_count <= dec.clocks;
			addr_mode <= dec.mode;
			data_mem_access <= dec.mode != MODE_NONE && dec.mode != MODE_IMM
				&& dec.mode != MODE_IDX; // [RL1] [RL6]
			ext_ram_access <= dec.ext; // [RL4]
			mem_write <= dec.wr;
			code_read <= dec.mode == MODE_IDX && !dec.jump; // [RL6]
			jump_valid <= dec.jump; // [RL7]
		end
	end

	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			operand_addr <= 16'h0000;
			sfr_select <= 1'b0;
			work_reg_index <= 5'h00;
			imm_value <= 16'h0000;
			code_addr <= 16'h0000;
			jump_target <= 16'h0000;
		end else if (clk_en && accept) begin
			operand_addr <= next_addr;
			sfr_select <= dec.mode == MODE_DIR && op_byte1 >= DIR_SFR_BASE; // [RL2]
			work_reg_index <= {psw_bank, dec.mode == MODE_REG ? opcode[2:0]
				: {2'b00, opcode[0]}}; // [RL23] [RL5]
			imm_value <= next_imm;
			code_addr <= idx_sum; // [RL6]
			jump_target <= idx_sum; // [RL7]
		end
	end

	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			acc_result <= 8'h00;
			carry <= 1'b0;
			aux_carry <= 1'b0;
			signed_wrap_flag <= 1'b0;
			flags_valid <= 1'b0;
		end else if (clk_en && accept) begin
			acc_result <= alu_bus.result;
			carry <= alu_bus.cy; // [RL21]
			aux_carry <= alu_bus.ac; // [RL21]
			signed_wrap_flag <= alu_bus.ov; // [RL22]
			flags_valid <= alu_bus.flags;
		end
	end
	// Checks; cycles are counted on enabled edges only
	logic [8:0] chk_sum;
	logic [7:0] chk_low7;
	assign chk_sum = {1'b0, acc} + {1'b0, alu_b};
	assign chk_low7 = {1'b0, acc[6:0]} + {1'b0, alu_b[6:0]};

	default clocking cb @(posedge clock iff clk_en); endclocking
	default disable iff (!rst_n_sync);
	sequence s_two; !done ##1 done; endsequence
	sequence s_three; !done [*2] ##1 done; endsequence
	sequence s_four; !done [*3] ##1 done; endsequence
	a_imm_no_dmem: assert property (accept && dec.mode == MODE_IMM // [RL1]
		|=> !data_mem_access && imm_value[7:0] == ($past(opcode)
		== 8'h90 ? $past(op_byte2) : $past(op_byte1)))
		else $error("immediate operand wrong or touched data memory");
	a_dir_sfr_split: assert property (accept && dec.mode == MODE_DIR // [RL2]
		|=> sfr_select == $past(op_byte1[7]) && operand_addr[15:8] == 8'h00)
		else $error("direct address split wrong");
	a_ind8_source: assert property (accept && dec.mode == MODE_IND8 // [RL3]
		|=> operand_addr[7:0] == ($past(opcode[0]) ? $past(pointer_reg_one)
		: $past(pointer_reg_zero)))
		else $error("8-bit indirect address not from pointer register");
	a_ind16_table: assert property (accept && dec.mode == MODE_IND16 // [RL4]
		|=> operand_addr == $past(table_pointer16) && ext_ram_access)
		else $error("16-bit indirect address not from table pointer");
	a_reg_bank_index: assert property (accept && dec.mode == MODE_REG // [RL5]
		|=> work_reg_index == {$past(psw_bank), $past(opcode[2:0])})
		else $error("working register index wrong");
	a_idx_code_only: assert property (accept && opcode == 8'h93 // [RL6]
		|=> code_read && !data_mem_access && !mem_write
		&& code_addr == $past(table_pointer16) + {8'h00, $past(acc)})
		else $error("table read not a code-only base plus acc read");
	a_jump_sum: assert property (accept && opcode == 8'h73 // [RL7]
		|=> jump_valid && jump_target == $past(table_pointer16)
		+ {8'h00, $past(acc)})
		else $error("indexed jump target wrong");
	a_add_reg_two: assert property (accept // [RL8]
		&& opcode[7:5] == 3'b001 && opcode[3] |=> s_two)
		else $error("add from register not 2 clocks");
	a_diff_with_borrow_ind_three: assert property (accept // [RL9]
		&& opcode[7:1] == 7'b1001_011 |=> s_three)
		else $error("subtract from indirect not 3 clocks");
	a_logic_dir_three: assert property (accept && (opcode == 8'h55 // [RL10]
		|| opcode == 8'h45 || opcode == 8'h65) |=> s_three)
		else $error("logic from direct not 3 clocks");
	a_logic_dest_four: assert property (accept && opcode == 8'h53 // [RL11]
		|=> byte_len == LEN_3 ##0 s_four)
		else $error("logic to direct with immediate not 4 clocks 3 bytes");
	a_rotate_one: assert property (accept && opcode[7:6] == 2'b00 // [RL12]
		&& opcode[3:0] == 4'h3 |=> done && byte_len == LEN_1)
		else $error("rotate not 1 clock 1 byte");
	a_ext_write_four: assert property (accept // [RL17]
		&& opcode[7:1] == 7'b1111_001 |=> mem_write ##0 s_four)
		else $error("external write via pointer not 4 clocks");
	a_push_four: assert property (accept && opcode == 8'hc0 // [RL18]
		|=> byte_len == LEN_2 ##0 s_four)
		else $error("push not 4 clocks 2 bytes");
	a_add_carries: assert property (accept && opcode[7:4] == 4'h2 // [RL21]
		&& opcode[3:2] != 2'b00 |=> flags_valid
		&& carry == $past(chk_sum[8])
		&& signed_wrap_flag == ($past(chk_sum[8]) ^ $past(chk_low7[7])))
		else $error("add carry or signed wrap flag wrong"); // [RL22]
endmodule : sco_core
`default_nettype wire

//--- dv/sco_mem_model.sv
// Behavioural program memory and data RAM facing the decoder
`timescale 1ns/1ps
`default_nettype none
module sco_mem_model (
	// Code fetch
	input wire logic fetch_en,
	input wire logic [15:0] fetch_ptr,
	output logic [7:0] opcode,
	output logic [7:0] op_byte1,
	output logic [7:0] op_byte2,
	// Data read
	input wire logic [7:0] data_addr,
	output logic [7:0] data_byte
);
	logic [7:0] code [0:255];
	logic [7:0] ram [0:255];
	logic [7:0] ptr;
	assign ptr = fetch_ptr[7:0];
	// Bytes not on offer show the inverse, so a stale fetch cannot pass
	assign opcode = fetch_en ? code[ptr] : ~code[ptr];
	assign op_byte1 = fetch_en ? code[ptr + 8'h1] : ~code[ptr + 8'h1];
	assign op_byte2 = fetch_en ? code[ptr + 8'h2] : ~code[ptr + 8'h2];
	assign data_byte = ram[data_addr];
endmodule : sco_mem_model
`default_nettype wire

//--- dv/sco_core_tb_top.sv
// Self-checking testbench for the operand and timing decoder
`timescale 1ns/1ps
`default_nettype none
module sco_core_tb_top
	import sco_pkg::*;
;
	logic clock, rstn, clk_en, op_valid, carry_in;
	logic [7:0] acc, pointer_reg_zero, pointer_reg_one, stack_ptr, data_addr;
	logic [15:0] table_pointer16, prog_counter, fetch_ptr;
	logic [1:0] psw_bank;
	logic [7:0] opcode, op_byte1, op_byte2, src_operand, acc_result;
	logic op_ready, busy, done, known_op, sfr_select, data_mem_access;
	logic ext_ram_access, mem_write, code_read, jump_valid, carry;
	logic aux_carry, signed_wrap_flag, flags_valid;
	logic [1:0] byte_len;
	logic [2:0] clock_count;
	logic [4:0] work_reg_index;
	logic [15:0] operand_addr, imm_value, code_addr, jump_target;
	sco_mode_t addr_mode;
	int mismatches, n_tests, cycles;
	// Opcode, clocks and length per entry, one nibble each for the last two
	logic [15:0] tbl [0:56] = '{
		16'h2821, 16'h2532, 16'h2631, 16'h2422, 16'h3821, 16'h3532,
		16'h3631, 16'h3422, 16'h9821, 16'h9532, 16'h9631, 16'h9422,
		16'h5821, 16'h5532, 16'h5631, 16'h5422, 16'h5242, 16'h5343,
		16'h4821, 16'h4532, 16'h4631, 16'h4422, 16'h4242, 16'h4343,
		16'h6821, 16'h6532, 16'h6631, 16'h6422, 16'h6242, 16'h6343,
		16'he411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hc411,
		16'hd641, 16'he811, 16'he522, 16'he621, 16'h7422, 16'h8543,
		16'h7533, 16'h9341, 16'h8341, 16'he231, 16'hf241, 16'he031,
		16'hf031, 16'hc042, 16'hd032, 16'hc831, 16'hc542, 16'hc641,
		16'hf821, 16'hf532, 16'hf631};

	sco_mem_model sco_mem_model_inst (.fetch_en(op_valid),
		.fetch_ptr(fetch_ptr), .opcode(opcode), .op_byte1(op_byte1),
		.op_byte2(op_byte2), .data_addr(data_addr), .data_byte(src_operand));

	sco_core sco_core_inst (.clock(clock), .rstn(rstn), .clk_en(clk_en),
		.op_valid(op_valid), .op_ready(op_ready), .opcode(opcode),
		.op_byte1(op_byte1), .op_byte2(op_byte2), .acc(acc),
		.carry_in(carry_in), .psw_bank(psw_bank),
		.pointer_reg_zero(pointer_reg_zero), .pointer_reg_one(pointer_reg_one),
		.stack_ptr(stack_ptr), .table_pointer16(table_pointer16),
		.prog_counter(prog_counter), .src_operand(src_operand), .busy(busy),
		.done(done), .known_op(known_op), .byte_len(byte_len),
		.clock_count(clock_count), .addr_mode(addr_mode),
		.operand_addr(operand_addr), .sfr_select(sfr_select),
		.work_reg_index(work_reg_index), .imm_value(imm_value),
		.data_mem_access(data_mem_access), .ext_ram_access(ext_ram_access),
		.mem_write(mem_write), .code_read(code_read), .code_addr(code_addr),
		.jump_valid(jump_valid), .jump_target(jump_target),
		.acc_result(acc_result), .carry(carry), .aux_carry(aux_carry),
		.signed_wrap_flag(signed_wrap_flag), .flags_valid(flags_valid));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic final_report();
		$display("compares %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// A hung handshake ends the run here
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic chk_v(input logic [15:0] got, exp, input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_v

	task automatic chk_t(input int got, exp, input string what);
		n_tests++;
		if (got != exp) begin
			mismatches++;
			$display("mismatch %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask : chk_t

	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (done !== 1'b1 && n < 20);
	endtask : wait_done

	// Request held until an edge sees op_ready high
	task automatic issue(input logic [7:0] b0, b1);
		logic ok;
		int k;
		sco_mem_model_inst.code[0] = b0;
		sco_mem_model_inst.code[1] = b1;
		sco_mem_model_inst.code[2] = 8'h40;
		@(posedge clock);
		op_valid <= 1'b1;
		k = 0;
		do begin
			@(negedge clock);
			ok = op_ready;
			@(posedge clock);
			k++;
		end while (ok !== 1'b1 && k < 20);
		op_valid <= 1'b0;
	endtask : issue

	task automatic run(input logic [7:0] b0, b1, output int n);
		issue(b0, b1);
		wait_done(n);
	endtask : run

	task automatic run_table(input int first, last);
		int n;
		for (int i = first; i <= last; i++) begin
			run(tbl[i][15:8], 8'h30, n);
			chk_t(n, int'(tbl[i][7:4]), "clocks to done");
			chk_v(16'(clock_count), 16'(tbl[i][7:4]), "clock_count");
			chk_v(16'(byte_len), 16'(tbl[i][3:0]), "byte_len");
			chk_v(16'(known_op), 16'h0001, "known_op");
			chk_v(16'(busy), 16'h0001, "busy in done cycle");
		end
	endtask : run_table

	task automatic t_timing();
		run_table(0, 11);
		run_table(12, 29);
		run_table(30, 36);
		run_table(37, 44);
		run_table(45, 56);
		$display("test timing done");
	endtask : t_timing

	task automatic t_flags();
		logic [31:0] av, bv;
		logic [8:0] s;
		logic [7:0] a, b;
		logic c3, c6;
		int n;
		av = 32'hc37f0f80;
		bv = 32'haa010180;
		for (int i = 0; i < 4; i++) begin
			a = av[31 - 8 * i -: 8];
			b = bv[31 - 8 * i -: 8];
			@(posedge clock);
			acc <= a;
			carry_in <= 1'b1;
			sco_mem_model_inst.ram[8'h10] = b;
			run(i[0] ? 8'h38 : 8'h28, 8'h00, n);
			s = 9'(a) + 9'(b) + 9'(i[0]);
			c3 = (5'(a[3:0]) + 5'(b[3:0]) + 5'(i[0])) > 5'hf;
			c6 = (8'(a[6:0]) + 8'(b[6:0]) + 8'(i[0])) > 8'h7f;
			chk_v(16'(acc_result), 16'(s[7:0]), "sum");
			chk_v(16'(carry), 16'(s[8]), "carry");
			chk_v(16'(aux_carry), 16'(c3), "aux carry");
			chk_v(16'(signed_wrap_flag), 16'(c6 ^ s[8]), "wrap");
			chk_v(16'(flags_valid), 16'h0001, "flags valid");
		end
		$display("test flags done");
	endtask : t_flags

	task automatic t_addr();
		int n;
		@(posedge clock);
		acc <= 8'h05;
		sco_mem_model_inst.ram[8'h10] = 8'h11;
		run(8'h24, 8'h70, n);
		chk_v(16'(acc_result), 16'h0075, "imm sum");
		chk_v(16'(data_mem_access), 16'h0000, "imm ram");
		chk_v(16'(addr_mode), 16'(MODE_IMM), "imm mode");
		chk_v(imm_value, 16'h0070, "imm value");
		run(8'h75, 8'h30, n);
		chk_v(imm_value, 16'h0040, "imm to direct");
		run(8'h25, 8'h30, n);
		chk_v(operand_addr, 16'h0030, "dir addr");
		chk_v(16'(sfr_select), 16'h0000, "low ram");
		run(8'h25, 8'h90, n);
		chk_v(16'(sfr_select), 16'h0001, "sfr");
		run(8'h26, 8'h00, n);
		chk_v(operand_addr, 16'h0021, "ptr zero");
		run(8'h27, 8'h00, n);
		chk_v(operand_addr, 16'h005e, "ptr one");
		run(8'hc0, 8'h30, n);
		chk_v(operand_addr, 16'h0047, "stack");
		run(8'he0, 8'h00, n);
		chk_v(operand_addr, 16'h1234, "table ptr");
		chk_v(16'(ext_ram_access), 16'h0001, "ext read");
		run(8'hf0, 8'h00, n);
		chk_v(16'(mem_write), 16'h0001, "ext write");
		@(posedge clock);
		psw_bank <= 2'h2;
		run(8'h2d, 8'h00, n);
		chk_v(16'(work_reg_index), 16'h0015, "bank reg");
		chk_v(16'(addr_mode), 16'(MODE_REG), "reg mode");
		$display("test addressing done");
	endtask : t_addr

	task automatic t_index();
		int n;
		@(posedge clock);
		acc <= 8'hf3;
		table_pointer16 <= 16'h12f0;
		prog_counter <= 16'h0ff0;
		run(8'h93, 8'h00, n);
		chk_v(code_addr, 16'h13e3, "table base");
		chk_v(16'(code_read), 16'h0001, "code read");
		chk_v(16'(mem_write), 16'h0000, "no write");
		run(8'h83, 8'h00, n);
		chk_v(code_addr, 16'h10e3, "counter base");
		run(8'h73, 8'h00, n);
		chk_v(16'(jump_valid), 16'h0001, "jump");
		chk_v(jump_target, 16'h13e3, "jump target");
		$display("test indexed done");
	endtask : t_index

	// Request kept up through the done cycle: the next accept follows at once
	task automatic t_b2b();
		int n, m;
		sco_mem_model_inst.code[0] = 8'h24;
		@(posedge clock);
		op_valid <= 1'b1;
		wait_done(n);
		wait_done(m);
		chk_t(m, 2, "back to back");
		@(posedge clock);
		op_valid <= 1'b0;
		wait_done(n);
		$display("test back to back done");
	endtask : t_b2b

	// Disabled cycles must not count towards the four clocks
	task automatic t_stall();
		int n;
		issue(8'h85, 8'h30);
		@(posedge clock);
		clk_en <= 1'b0;
		repeat (3) @(posedge clock);
		clk_en <= 1'b1;
		wait_done(n);
		chk_t(1 + 3 + n, 4 + 3, "stalled copy");
		$display("test stall done");
	endtask : t_stall

	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		op_valid = 1'b0;
		acc = 8'h00;
		carry_in = 1'b0;
		psw_bank = 2'h0;
		pointer_reg_zero = 8'h21;
		pointer_reg_one = 8'h5e;
		stack_ptr = 8'h47;
		table_pointer16 = 16'h1234;
		prog_counter = 16'h0200;
		fetch_ptr = 16'h0000;
		data_addr = 8'h10;
		mismatches = 0;
		n_tests = 0;
		sco_mem_model_inst.ram[8'h10] = 8'h3c;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		t_timing();
		t_flags();
		t_addr();
		t_index();
		t_b2b();
		t_stall();
		final_report();
	end
endmodule : sco_core_tb_top
`default_nettype wire
